// ===== include/efs_defines.svh
// Constants for the parallel-port FIFO service block.
// Assumes inclusion by the package and the design file only.
`ifndef EFS_DEFINES_SVH
`define EFS_DEFINES_SVH
`define EFS_FIFO_DEPTH 16
`define EFS_MODE_COMPAT 3'h0
`define EFS_MODE_PS2 3'h1
`define EFS_MODE_FIFO 3'h2
`define EFS_MODE_ECP 3'h3
`define EFS_MODE_TEST 3'h6
`define EFS_OFS_ADDR_Q 11'h000
`define EFS_OFS_DATA_Q 11'h400
`define EFS_OFS_CTRL 11'h402
`define EFS_OFS_CFG 11'h403
`define EFS_OFS_STAT 11'h404
`define EFS_DMA_BURST_MAX 6'h20
`define EFS_THR_CLAMP 5'h0F
`endif

// ===== include/efs_pkg.sv
// Types for the parallel-port FIFO service block.
// Assumes efs_defines.svh is on the include path.
`include "efs_defines.svh"
package efs_pkg;
    typedef struct packed {
        logic service_interrupt_disable;
        logic dma_transfer_enable;
        logic direction;
        logic fault_interrupt_enable_n;
        logic acknowledge_interrupt_enable;
        logic [2:0] mode;
        logic [3:0] fifo_level_setting;
    } efs_ctrl_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [10:0] addr;
        logic [7:0] wdata;
    } efs_pio_t;
    typedef enum logic [2:0] {
        EFS_DQ_IDLE = 3'h1,
        EFS_DQ_REQ = 3'h2,
        EFS_DQ_HOLD = 3'h4
    } efs_dq_t;
endpackage

// ===== hdl/efs_fifo_service.sv
// FIFO service and DMA request control for the extended parallel port.
// Assumes host-side strobes are synchronous to clk; nFault and nAck are
// asynchronous pins; the link side pushes and pops through plain ports.
// How it works
// - Control line drivers are open-collector in mode 000, push-pull else.
// - FIFO to DMA moves are single bytes, aligned, whole.
// - Service disable bit blocks DMA requests and FIFO service interrupts.
// - Clearing the disable bit fires at once if a condition holds.
// - Terminal count with DMA enabled and service on raises interrupt.
// - PIO forward: interrupt while free space reaches forward free level.
// - PIO reverse: interrupt while byte count reaches reverse fill level.
// - Fault interrupt on nFault fall, or enable cleared while asserted.
// - Acknowledge interrupt on each nAck rise when enabled.
// - FIFO stays disabled after reset until a FIFO mode is chosen.
// - Threshold equals level setting plus one, from 1 to 16.
// - Threshold 16 behaves like threshold 15.
// - DMA targets data, test or compat queue, never address queue.
// - DMA request goes out on the request line; FIFO moves by direction.
// - Terminal count interrupts and sets the service disable bit.
// - DMA request never held for more than 32 consecutive DMA cycles.
// - Any DMA cycle on the channel accesses the FIFO, address ignored.
// - Reverse DMA requested while data held; stops on empty or count.
// - Re-request on one byte; after count also needs service re-enabled.
// - PIO writes data at 400H, address at 000H; reads at 400H.
// - Reverse fill level is sixteen minus threshold bytes held.
// - Forward free level is sixteen minus threshold free locations.
`timescale 1ns/1ps
`include "efs_defines.svh"
module efs_fifo_service #(
    parameter int DEPTH = `EFS_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [10:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    // DMA port: cycle strobe, terminal count, write data, read data, request
    input wire logic dma_cycle,
    input wire logic dma_tc,
    input wire logic [7:0] dma_wdata,
    output logic [7:0] dma_rdata,
    output logic dma_req,
    // Link side FIFO access
    input wire logic link_push,
    input wire logic [7:0] link_wdata,
    input wire logic link_pop,
    output logic [7:0] link_rdata,
    output logic link_rdata_is_addr,
    output logic fifo_full,
    output logic fifo_empty,
    // Port pins
    input wire logic fault_n_pin,
    input wire logic ack_n_pin,
    output logic ctl_push_pull,
    // Service and status
    output logic service_irq,
    output logic fault_irq,
    output logic ack_irq,
    output efs_pkg::efs_ctrl_t ctrl
);
    import efs_pkg::*;

    localparam int CW = $clog2(DEPTH + 1);
    localparam int AW = $clog2(DEPTH);
    localparam logic [10:0] OFS_CTRL = `EFS_OFS_CTRL;
    localparam logic [10:0] OFS_CFG = `EFS_OFS_CFG;
    localparam logic [10:0] OFS_STAT = `EFS_OFS_STAT;

    logic [7:0] mem_r [DEPTH];
    logic [DEPTH-1:0] tag_r;
    logic [AW-1:0] wp_r, rp_r;
    logic [CW-1:0] cnt_r;
    efs_ctrl_t ctrl_r;
    efs_dq_t dq_r;
    logic [5:0] burst_r;
    logic tc_stop_r;
    logic fsync1_r, fsync2_r, fprev_r;
    logic async1_r, async2_r, aprev_r;
    logic sid_prev_r;
    logic fen_prev_r;
    logic [7:0] rdata_r, dma_rdata_r, link_rdata_r;
    logic link_tag_r;
    logic fault_irq_r, ack_irq_r;

    // Effective threshold, with 16 folded down to 15
    function automatic logic [4:0] eff_thr(input logic [3:0] lvl);
        logic [4:0] t;
        t = {1'b0, lvl} + 5'h01;
        if (t > `EFS_THR_CLAMP)
            t = `EFS_THR_CLAMP;
        return t;
    endfunction

    function automatic logic fifo_mode(input logic [2:0] m);
        return m == `EFS_MODE_FIFO || m == `EFS_MODE_ECP ||
            m == `EFS_MODE_TEST;
    endfunction

    logic [4:0] thr;
    logic [4:0] level;
    logic fifo_on;
    logic [CW-1:0] free_cnt;
    logic host_wr_fifo, host_rd_fifo, dma_wr, dma_rd;
    logic push, pop;
    logic [7:0] push_data;
    logic push_tag;
    logic pio_cond, svc_cond, sid_fall;
    logic fault_fall, ack_rise, fen_clear;

    assign thr = eff_thr(ctrl_r.fifo_level_setting);
    assign level = 5'h10 - thr;
    assign fifo_on = fifo_mode(ctrl_r.mode);
    assign free_cnt = CW'(DEPTH) - cnt_r;
    assign fifo_full = cnt_r == CW'(DEPTH);
    assign fifo_empty = cnt_r == '0;

    // Host pushes in forward, DMA uses the data queue only
    assign host_wr_fifo = wr_stb && fifo_on && !ctrl_r.direction &&
        (addr == `EFS_OFS_DATA_Q || addr == `EFS_OFS_ADDR_Q);
    assign host_rd_fifo = rd_stb && fifo_on && addr == `EFS_OFS_DATA_Q &&
        (ctrl_r.direction || ctrl_r.mode == `EFS_MODE_TEST);
    // Address ignored on DMA cycles; direction picks the move
    assign dma_wr = dma_cycle && fifo_on && !ctrl_r.direction;
    assign dma_rd = dma_cycle && fifo_on && ctrl_r.direction;
    assign push = (host_wr_fifo || dma_wr ||
        (link_push && ctrl_r.direction)) && !fifo_full;
    assign pop = (host_rd_fifo || dma_rd ||
        (link_pop && !ctrl_r.direction)) && !fifo_empty;
    assign push_data = dma_wr ? dma_wdata :
        (host_wr_fifo ? wdata : link_wdata);
    assign push_tag = host_wr_fifo && addr == `EFS_OFS_ADDR_Q;

    // Storage and pointers; FIFO flushed whenever not in a FIFO mode
    always_ff @(posedge clk) begin
        if (srst || !fifo_on) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push)
                wp_r <= AW'(wp_r + 1'b1);
            if (pop)
                rp_r <= AW'(rp_r + 1'b1);
            if (push && !pop)
                cnt_r <= CW'(cnt_r + 1'b1);
            else if (pop && !push)
                cnt_r <= CW'(cnt_r - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= push_data;
            tag_r[wp_r] <= push_tag;
        end
    end

    // Read data of the DMA and link consumers, byte wide
    always_ff @(posedge clk) begin
        if (srst) begin
            dma_rdata_r <= 8'h00;
            link_rdata_r <= 8'h00;
            link_tag_r <= 1'b0;
        end else if (pop) begin
            dma_rdata_r <= mem_r[rp_r];
            link_rdata_r <= mem_r[rp_r];
            link_tag_r <= tag_r[rp_r];
        end
    end

    // Control register; terminal count sets the disable bit, set wins
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_r <= '0;
            ctrl_r.service_interrupt_disable <= 1'b1;
            ctrl_r.fault_interrupt_enable_n <= 1'b1;
        end else begin
            if (wr_stb && addr == OFS_CTRL) begin
                ctrl_r.service_interrupt_disable <= wdata[2];
                ctrl_r.dma_transfer_enable <= wdata[3];
                ctrl_r.mode <= wdata[7:5];
            end
            if (wr_stb && addr == OFS_CFG) begin
                ctrl_r.fifo_level_setting <= wdata[3:0];
                ctrl_r.direction <= wdata[4];
                ctrl_r.fault_interrupt_enable_n <= wdata[5];
                ctrl_r.acknowledge_interrupt_enable <= wdata[6];
            end
            if (dma_cycle && dma_tc && ctrl_r.dma_transfer_enable)
                ctrl_r.service_interrupt_disable <= 1'b1;
        end
    end

    // Register reads, answered one cycle later
    always_ff @(posedge clk) begin
        if (srst)
            rdata_r <= 8'h00;
        else if (rd_stb) begin
            case (addr)
                `EFS_OFS_DATA_Q: rdata_r <= host_rd_fifo ?
                    mem_r[rp_r] : 8'h00;
                OFS_CTRL: rdata_r <= {ctrl_r.mode,
                    service_irq, ctrl_r.dma_transfer_enable,
                    ctrl_r.service_interrupt_disable, fifo_full,
                    fifo_empty};
                OFS_CFG: rdata_r <= {1'b0,
                    ctrl_r.acknowledge_interrupt_enable,
                    ctrl_r.fault_interrupt_enable_n, ctrl_r.direction,
                    ctrl_r.fifo_level_setting};
                OFS_STAT: rdata_r <= {3'h0, cnt_r};
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    // Pin synchronisers; only second and third stages are examined
    always_ff @(posedge clk) begin
        if (srst) begin
            fsync1_r <= 1'b1;
            fsync2_r <= 1'b1;
            fprev_r <= 1'b1;
            async1_r <= 1'b1;
            async2_r <= 1'b1;
            aprev_r <= 1'b1;
        end else begin
            fsync1_r <= fault_n_pin;
            fsync2_r <= fsync1_r;
            fprev_r <= fsync2_r;
            async1_r <= ack_n_pin;
            async2_r <= async1_r;
            aprev_r <= async2_r;
        end
    end

    assign fault_fall = fprev_r && !fsync2_r;
    assign ack_rise = !aprev_r && async2_r;
    assign fen_clear = fen_prev_r && !ctrl_r.fault_interrupt_enable_n;

    // Fault and acknowledge interrupts are one-cycle pulses
    always_ff @(posedge clk) begin
        if (srst) begin
            fen_prev_r <= 1'b1;
            fault_irq_r <= 1'b0;
            ack_irq_r <= 1'b0;
        end else begin
            fen_prev_r <= ctrl_r.fault_interrupt_enable_n;
            fault_irq_r <= (!ctrl_r.fault_interrupt_enable_n && fault_fall)
                || (fen_clear && !fsync2_r);
            ack_irq_r <= ctrl_r.acknowledge_interrupt_enable
                && ack_rise;
        end
    end

    // Programmed I/O service condition by direction
    assign pio_cond = !ctrl_r.dma_transfer_enable && fifo_on &&
        (ctrl_r.direction ? (5'(cnt_r) >= level)
                          : (5'(free_cnt) >= level));
    assign svc_cond = !ctrl_r.service_interrupt_disable && pio_cond;
    assign sid_fall = sid_prev_r && !ctrl_r.service_interrupt_disable;

    // Previous disable bit, to find its 1 to 0 edge
    always_ff @(posedge clk) begin
        if (srst) begin
            sid_prev_r <= 1'b1;
        end else begin
            sid_prev_r <= ctrl_r.service_interrupt_disable;
        end
    end

    // Service interrupt: level while PIO condition holds, pulse on TC
    always_comb begin
        service_irq = svc_cond;
        if (dma_cycle && dma_tc && ctrl_r.dma_transfer_enable &&
            !ctrl_r.service_interrupt_disable)
            service_irq = 1'b1;
    end

    // DMA request state: burst limit and stop after terminal count
    logic dma_want;
    assign dma_want = ctrl_r.dma_transfer_enable && fifo_on &&
        !ctrl_r.service_interrupt_disable && !tc_stop_r &&
        (ctrl_r.direction ? !fifo_empty : !fifo_full);

    always_ff @(posedge clk) begin
        if (srst)
            tc_stop_r <= 1'b0;
        else if (dma_cycle && dma_tc)
            tc_stop_r <= 1'b1;
        else if (sid_fall)
            tc_stop_r <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dq_r <= EFS_DQ_IDLE;
            burst_r <= 6'h00;
        end else begin
            case (dq_r)
                EFS_DQ_IDLE: begin
                    burst_r <= 6'h00;
                    if (dma_want)
                        dq_r <= EFS_DQ_REQ;
                end
                EFS_DQ_REQ: begin
                    if (!dma_want || (dma_cycle && dma_tc))
                        dq_r <= EFS_DQ_IDLE;
                    else if (dma_cycle) begin
                        burst_r <= burst_r + 6'h01;
                        if (burst_r + 6'h01 >= `EFS_DMA_BURST_MAX)
                            dq_r <= EFS_DQ_HOLD;
                    end
                end
                EFS_DQ_HOLD: dq_r <= EFS_DQ_IDLE; // Gap for refresh
                default: dq_r <= EFS_DQ_IDLE;
            endcase
        end
    end

    assign dma_req = dq_r == EFS_DQ_REQ && dma_want;
    assign ctl_push_pull = ctrl_r.mode != `EFS_MODE_COMPAT;
    assign rdata = rdata_r;
    assign dma_rdata = dma_rdata_r;
    assign link_rdata = link_rdata_r;
    assign link_rdata_is_addr = link_tag_r;
    assign fault_irq = fault_irq_r;
    assign ack_irq = ack_irq_r;
    assign ctrl = ctrl_r;

    a_tc_sets_disable: assert property (@(posedge clk) disable iff (srst)
        dma_cycle && dma_tc && ctrl_r.dma_transfer_enable |=>
        ctrl_r.service_interrupt_disable)
        else $error("terminal count did not set disable");
    a_disable_blocks: assert property (@(posedge clk) disable iff (srst)
        ctrl_r.service_interrupt_disable |-> !dma_req && !svc_cond)
        else $error("request while service disabled");
    a_burst_limit: assert property (@(posedge clk) disable iff (srst)
        burst_r <= `EFS_DMA_BURST_MAX)
        else $error("dma burst too long");
    a_push_pull_mode: assert property (@(posedge clk) disable iff (srst)
        ctl_push_pull == (ctrl_r.mode != 3'h0))
        else $error("driver type wrong for mode");
    a_fifo_off_empty: assert property (@(posedge clk) disable iff (srst)
        !fifo_on |=> cnt_r == '0)
        else $error("fifo not held empty");
    a_thr_range: assert property (@(posedge clk) disable iff (srst)
        thr >= 5'h01 && thr <= 5'h0F)
        else $error("threshold out of range");
    a_ack_pulse: assert property (@(posedge clk) disable iff (srst)
        ctrl_r.acknowledge_interrupt_enable && !aprev_r && async2_r |=>
        ack_irq)
        else $error("ack rise missed");
    a_fault_pulse: assert property (@(posedge clk) disable iff (srst)
        !ctrl_r.fault_interrupt_enable_n && fprev_r && !fsync2_r |=>
        fault_irq)
        else $error("fault fall missed");
    a_rev_empty_stop: assert property (@(posedge clk) disable iff (srst)
        ctrl_r.direction && fifo_empty |-> !dma_req)
        else $error("reverse request while empty");
    a_count_bound: assert property (@(posedge clk) disable iff (srst)
        cnt_r <= CW'(DEPTH))
        else $error("occupancy above depth");
    a_clear_fires: assert property (@(posedge clk) disable iff (srst)
        sid_fall && pio_cond |-> service_irq)
        else $error("no interrupt when disable cleared");

    c_tc_seen: cover property (@(posedge clk) disable iff (srst)
        dma_req ##1 dma_cycle && dma_tc);
    c_burst_hold: cover property (@(posedge clk) disable iff (srst)
        dq_r == EFS_DQ_HOLD);
    c_pio_irq: cover property (@(posedge clk) disable iff (srst)
        sid_fall && svc_cond);
    c_fifo_full: cover property (@(posedge clk) disable iff (srst)
        fifo_full);
endmodule

// ===== bench/efs_link_model.sv
// Peripheral side of the link: moves bytes in and out of the FIFO.
// Assumes link_clk is slow beside clk; paced by its rising edges only.
`timescale 1ns/1ps
module efs_link_model (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Link pacing and test control
    input wire logic link_clk,
    input wire logic push_en,
    input wire logic pop_en,
    // FIFO state
    input wire logic fifo_full,
    input wire logic fifo_empty,
    // FIFO access
    output logic link_push,
    output logic [7:0] link_wdata,
    output logic link_pop
);
    logic [2:0] lc_r;
    logic [7:0] val_r;
    logic edge_seen;

    // Three flops: two to settle the foreign clock, one to find its rise
    always_ff @(posedge clk) begin
        lc_r <= {lc_r[1:0], link_clk};
    end
    assign edge_seen = lc_r[1] & ~lc_r[2];

    // One whole byte per link edge; idle data toggles so no stale byte
    always_ff @(posedge clk) begin
        if (srst) begin
            link_push <= 1'b0;
            link_pop <= 1'b0;
            link_wdata <= 8'h00;
            val_r <= 8'h30;
        end else begin
            link_push <= edge_seen & push_en & ~fifo_full;
            link_pop <= edge_seen & pop_en & ~fifo_empty;
            if (edge_seen & push_en & ~fifo_full) begin
                link_wdata <= val_r;
                val_r <= val_r + 8'h01;
            end else begin
                link_wdata <= ~link_wdata;
            end
        end
    end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the FIFO service block.
// Assumes the package, design and link model are compiled before it.
`timescale 1ns/1ps
module testbench;
    import efs_pkg::*;
    localparam logic [10:0] DQ = 11'h400;
    localparam logic [10:0] AQ = 11'h000;
    localparam logic [10:0] CT = 11'h402;
    localparam logic [10:0] CF = 11'h403;
    localparam logic [10:0] ST = 11'h404;
    logic clk = 1'b0, srst = 1'b1, link_clk = 1'b0, pop_d = 1'b0;
    logic [10:0] addr = 11'h000;
    logic [7:0] wdata = 8'h00, dma_wdata = 8'h00, rv;
    logic wr_stb = 1'b0, rd_stb = 1'b0, dma_cycle = 1'b0, dma_tc = 1'b0;
    logic fault_n_pin = 1'b1, ack_n_pin = 1'b1, push_en = 1'b0;
    logic pop_en = 1'b0;
    logic [7:0] rdata, dma_rdata, link_wdata, link_rdata;
    logic dma_req, link_push, link_pop, link_rdata_is_addr, fifo_full;
    logic fifo_empty, ctl_push_pull, service_irq, fault_irq, ack_irq;
    efs_ctrl_t ctrl;
    logic [8:0] exp_q[$];
    logic [8:0] e;
    int fails = 0, checks = 0, cyc = 0, pops = 0, burst = 0;
    int n_f = 0, n_a = 0;

    // Host clock and an unrelated, slower link clock
    always #12.5 clk = ~clk;
    always #100 link_clk = ~link_clk;

    efs_fifo_service i_dut (.clk, .srst, .addr, .wdata, .wr_stb, .rd_stb,
        .rdata, .dma_cycle, .dma_tc, .dma_wdata, .dma_rdata, .dma_req,
        .link_push, .link_wdata, .link_pop, .link_rdata, .link_rdata_is_addr,
        .fifo_full, .fifo_empty, .fault_n_pin, .ack_n_pin, .ctl_push_pull,
        .service_irq, .fault_irq, .ack_irq, .ctrl);
    efs_link_model i_link (.clk, .srst, .link_clk, .push_en, .pop_en,
        .fifo_full, .fifo_empty, .link_push, .link_wdata, .link_pop);

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
        #1;
    endtask

    // Read data is looked at only in the cycle after the strobe
    task automatic rd(input logic [10:0] a, input logic [7:0] x, m);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk("rdata", rdata & m, x);
    endtask

    // One host DMA cycle; a terminal count must pulse the interrupt
    task automatic dcyc(input logic [7:0] d, input logic tc);
        @(posedge clk);
        dma_cycle <= 1'b1;
        dma_tc <= tc;
        dma_wdata <= d;
        #1;
        chk("dma irq", service_irq, tc);
        @(posedge clk);
        dma_cycle <= 1'b0;
        dma_tc <= 1'b0;
        #1;
        chk("burst", burst <= 32, 1'b1);
    endtask

    function automatic logic pick(input int s);
        return s == 0 ? dma_req : (s == 1 ? fifo_empty : service_irq);
    endfunction

    // Bounded wait on request, empty or interrupt
    task automatic till(input int s, input logic v);
        for (int n = 0; n < 200 && pick(s) !== v; n++) @(posedge clk);
        #1;
        chk("wait", pick(s), v);
    endtask

    // Popped bytes, pulse counts, run of DMA cycles and the time limit
    always @(posedge clk) begin
        pop_d <= link_pop;
        burst <= (dma_req !== 1'b1) ? 0 : burst + (dma_cycle ? 1 : 0);
        if (fault_irq === 1'b1) n_f <= n_f + 1;
        if (ack_irq === 1'b1) n_a <= n_a + 1;
        if (pop_d) begin
            pops <= pops + 1;
            if (exp_q.size() == 0) chk("spare pop", 1'b1, 1'b0);
            else begin
                e = exp_q.pop_front();
                chk("link byte", link_rdata, e[7:0]);
                chk("addr tag", link_rdata_is_addr, e[8]);
            end
        end
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd(CT, 8'h05, 8'hFF);
        chk("ctrl", ctrl[11:4], 8'h90);
        chk("push pull", ctl_push_pull, 1'b0);
        wr(DQ, 8'h55);
        rd(ST, 8'h00, 8'h1F);
        for (int m = 0; m < 8; m++) begin
            wr(CT, 8'(m << 5) | 8'h04);
            chk("push pull", ctl_push_pull, m != 0);
            wr(CT, 8'h04);
        end
        // Forward PIO: threshold 12, level 4 free bytes
        wr(CF, 8'h2B);
        wr(CT, 8'h60);
        for (int i = 1; i <= 16; i++) begin
            exp_q.push_back({i == 1, 8'hA0 + 8'(i)});
            wr(i == 1 ? AQ : DQ, 8'hA0 + 8'(i));
            chk("fwd irq", service_irq, 16 - i >= 4);
        end
        rd(ST, 8'h10, 8'h1F);
        chk("full", fifo_full, 1'b1);
        wr(CT, 8'h64);
        chk("off irq", service_irq, 1'b0);
        pop_en <= 1'b1;
        for (int n = 0; n < 300 && pops < 8; n++) @(posedge clk);
        pop_en <= 1'b0;
        #1;
        chk("off irq", service_irq, 1'b0);
        wr(CT, 8'h60);
        chk("at once", service_irq, 1'b1);
        pop_en <= 1'b1;
        till(1, 1'b1);
        repeat (3) @(posedge clk);
        pop_en <= 1'b0;
        chk("drained", exp_q.size() == 0, 1'b1);
        // Test mode lets a forward data byte be read back at 400H
        wr(CT, 8'hC4);
        wr(DQ, 8'h5A);
        rd(DQ, 8'h5A, 8'hFF);
        // Reverse PIO: settings 14 and 15 give level 1, 13 gives 2
        wr(CT, 8'h24);
        wr(CF, 8'h3E);
        wr(CT, 8'h60);
        chk("rev irq", service_irq, 1'b0);
        chk("ctrl", ctrl[11:4], 8'h33);
        chk("ctrl lvl", 8'(ctrl.fifo_level_setting), 8'h0E);
        push_en <= 1'b1;
        till(1, 1'b0);
        push_en <= 1'b0;
        chk("rev irq", service_irq, 1'b1);
        wr(CF, 8'h3F);
        chk("thr 16", service_irq, 1'b1);
        wr(CF, 8'h3D);
        chk("thr 14", service_irq, 1'b0);
        push_en <= 1'b1;
        till(2, 1'b1);
        push_en <= 1'b0;
        rv = 8'h30;
        rd(DQ, rv, 8'hFF);
        rd(DQ, rv + 8'h01, 8'hFF);
        rv = rv + 8'h02;
        // Reverse DMA: request while data held, stop on empty and count
        wr(CT, 8'h6C);
        wr(CT, 8'h68);
        chk("no data", dma_req, 1'b0);
        push_en <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            till(0, 1'b1);
            dcyc(8'h00, 1'b0);
            chk("dma byte", dma_rdata, rv);
            rv++;
        end
        push_en <= 1'b0;
        for (int k = 0; k < 20 && fifo_empty !== 1'b1; k++) begin
            dcyc(8'h00, 1'b0);
            chk("dma byte", dma_rdata, rv);
            rv++;
        end
        repeat (2) @(posedge clk);
        #1;
        chk("empty req", dma_req, 1'b0);
        push_en <= 1'b1;
        till(0, 1'b1);
        push_en <= 1'b0;
        dcyc(8'h00, 1'b1);
        chk("tc byte", dma_rdata, rv);
        rv++;
        push_en <= 1'b1;
        till(1, 1'b0);
        push_en <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("after tc", dma_req, 1'b0);
        rd(CT, 8'h04, 8'h04);
        wr(CT, 8'h68);
        till(0, 1'b1);
        dcyc(8'h00, 1'b0);
        chk("dma byte", dma_rdata, rv);
        wr(CT, 8'h6C);
        wr(CT, 8'h64);
        chk("paused", dma_req, 1'b0);
        // Forward DMA paced at the same rate as the link drains it
        wr(CT, 8'h24);
        wr(CF, 8'h2B);
        wr(CT, 8'h44);
        wr(CT, 8'h4C);
        wr(CT, 8'h48);
        pop_en <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            till(0, 1'b1);
            exp_q.push_back({1'b0, 8'hC0 + 8'(k)});
            dcyc(8'hC0 + 8'(k), 1'b0);
            repeat (6) @(posedge clk);
        end
        wr(CT, 8'h4C);
        wr(CT, 8'h44);
        till(1, 1'b1);
        repeat (3) @(posedge clk);
        pop_en <= 1'b0;
        chk("dma drained", exp_q.size() == 0, 1'b1);
        // Fault and acknowledge pin events
        wr(CF, 8'h0B);
        fault_n_pin <= 1'b0;
        repeat (6) @(posedge clk);
        chk("fault fall", 8'(n_f), 8'h01);
        wr(CF, 8'h2B);
        wr(CF, 8'h0B);
        repeat (4) @(posedge clk);
        chk("fault enable", 8'(n_f), 8'h02);
        fault_n_pin <= 1'b1;
        wr(CF, 8'h6B);
        for (int k = 0; k < 2; k++) begin
            ack_n_pin <= 1'b0;
            repeat (6) @(posedge clk);
            ack_n_pin <= 1'b1;
            repeat (6) @(posedge clk);
            chk("ack rise", 8'(n_a), 8'h01);
            wr(CF, 8'h2B);
        end
        conclude();
    end
endmodule
